// >>> verilog/cics_pkg.sv
// Purpose: shared constants and types for the interrupt control block
// Assumes: 9-bit register address, 8-bit data
// Notes: control register is mirrored at four addresses
package cics_pkg;

  localparam int CICS_AW = 9;
  localparam int CICS_DW = 8;
  localparam int CICS_NPIN = 4;
  localparam int CICS_NEVT = 3;

  // mirrored control/status register addresses
  localparam logic [CICS_AW-1:0] CICS_ICS_OFS0 = 9'h00b;
  localparam logic [CICS_AW-1:0] CICS_ICS_OFS1 = 9'h08b;
  localparam logic [CICS_AW-1:0] CICS_ICS_OFS2 = 9'h10b;
  localparam logic [CICS_AW-1:0] CICS_ICS_OFS3 = 9'h18b;
  // port data, event status and event mask
  localparam logic [CICS_AW-1:0] CICS_PORT_B_DATA_OFS = 9'h020;
  localparam logic [CICS_AW-1:0] CICS_EVT_STS_OFS = 9'h021;
  localparam logic [CICS_AW-1:0] CICS_EVT_MSK_OFS = 9'h022;

  // bit positions of interrupt_control_status
  localparam int CICS_GLOBAL_EN_BIT = 7;
  localparam int CICS_PERIPH_EN_BIT = 6;
  localparam int CICS_TMR_EN_BIT = 5;
  localparam int CICS_EXT_EN_BIT = 4;
  localparam int CICS_CHG_EN_BIT = 3;
  localparam int CICS_TMR_FLAG_BIT = 2;
  localparam int CICS_EXT_FLAG_BIT = 1;
  localparam int CICS_CHG_FLAG_BIT = 0;

  localparam logic [CICS_DW-1:0] CICS_ICS_RST = 8'h00;
  localparam logic [CICS_NEVT-1:0] CICS_EVT_RST = 3'h0;
  localparam logic [CICS_NPIN-1:0] CICS_LATCH_RST = 4'h0;
  localparam logic [CICS_DW-1:0] CICS_RDATA_RST = 8'h00;

  typedef struct packed {
    logic [CICS_DW-1:0] ics;
    logic [CICS_NEVT-1:0] evt_sts;
    logic [CICS_NEVT-1:0] evt_msk;
    logic ext_prev;
    logic [CICS_DW-1:0] rdata;
    logic core_irq;
    logic irq;
  } cics_state_t;

  typedef struct packed {
    logic [CICS_NPIN-1:0] latch;
  } cics_chg_state_t;

endpackage

// >>> verilog/cics_chg_if.sv
// Purpose: carries upper port pins, relatch request and mismatch
// Assumes: one clock domain
// Notes: ctrl side is the register logic, det side the change detector
`timescale 1ns/1ps
interface cics_chg_if;
  logic [cics_pkg::CICS_NPIN-1:0] pins;
  logic relatch;
  logic mismatch;
  modport ctrl (output pins, output relatch, input mismatch);
  modport det (input pins, input relatch, output mismatch);
endinterface

// >>> verilog/cics_port_change.sv
// Purpose: latch of the upper port pins and mismatch detection
// Assumes: pins synchronous to the clock
// Notes: latch clears at reset, so high pins show a mismatch at once
`timescale 1ns/1ps
module cics_port_change (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // link to the register logic
  cics_chg_if.det chg
);

  cics_pkg::cics_chg_state_t st_ff;
  cics_pkg::cics_chg_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (chg.relatch) begin
      nxt_st.latch = chg.pins;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_ff.latch <= cics_pkg::CICS_LATCH_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign chg.mismatch = (chg.pins != st_ff.latch);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  relatch_ends_a: assert property (
    chg.relatch ##1 $stable(chg.pins) |-> !chg.mismatch)
    else $error("mismatch survives a relatch with steady pins");

  change_seen_a: assert property (
    !chg.mismatch && !chg.relatch ##1 $changed(chg.pins) |-> chg.mismatch)
    else $error("pin change not seen as mismatch");

endmodule

// >>> verilog/cics_top.sv
// Purpose: interrupt control/status register and core request logic
// Assumes: pins and strobes synchronous to I_CORE_CLK (25 MHz)
// Notes: read data valid only in the cycle after the read strobe
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps

// How it works
// - each flag sets on its event regardless of any enable bit
// - bit 7 global enable: clear blocks all core requests (not O_IRQ), set lets enabled sources in
// - control register reads and writes at four mirrored addresses
// - bit 5 lets the timer overflow flag request an interrupt
// - bit 4 lets the external pin flag request an interrupt
// - port change flag sets when upper port pins differ from latch
// - persisting mismatch keeps setting port change flag over clears
// - reading port data relatches pins; clear flag only after that
// - hardware never clears flags; only software writing zero does
// - register holds enable and flag for timer, port change, ext pin
// - bit 6 gates all peripheral requests as one group
module cics_top (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  // register port
  input wire logic [cics_pkg::CICS_AW-1:0] I_ADDR,
  input wire logic [cics_pkg::CICS_DW-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [cics_pkg::CICS_DW-1:0] O_RDATA,
  // event sources
  input wire logic I_TIMER_WRAP,
  input wire logic I_EXT_IRQ_PIN,
  input wire logic I_EXT_EDGE_RISING,
  input wire logic [cics_pkg::CICS_NPIN-1:0] I_UPPER_PORT_PINS,
  input wire logic I_PERIPH_REQ,
  // interrupt outputs
  output logic O_CORE_IRQ,
  output logic O_IRQ
);

  cics_pkg::cics_state_t st_ff;
  cics_pkg::cics_state_t nxt_st;

  logic ics_hit;
  logic wr_ics;
  logic rd_port;
  logic wr_sts;
  logic wr_msk;
  logic ext_edge;
  logic [cics_pkg::CICS_NEVT-1:0] evt_now;

  cics_chg_if chg ();

  assign chg.pins = I_UPPER_PORT_PINS;
  assign chg.relatch = rd_port;

  cics_port_change u_port_change (
    .i_clk(I_CORE_CLK),
    .i_reset(I_RESET),
    .chg(chg)
  );

  // mirrored decode of the control register
  always_comb begin
    ics_hit = (I_ADDR == cics_pkg::CICS_ICS_OFS0) ||
              (I_ADDR == cics_pkg::CICS_ICS_OFS1) ||
              (I_ADDR == cics_pkg::CICS_ICS_OFS2) ||
              (I_ADDR == cics_pkg::CICS_ICS_OFS3);
  end

  assign wr_ics = I_WR && ics_hit;
  assign rd_port = I_RD && (I_ADDR == cics_pkg::CICS_PORT_B_DATA_OFS);
  assign wr_sts = I_WR && (I_ADDR == cics_pkg::CICS_EVT_STS_OFS);
  assign wr_msk = I_WR && (I_ADDR == cics_pkg::CICS_EVT_MSK_OFS);

  // pin is taken as synchronous, so one previous sample is enough
  assign ext_edge = I_EXT_EDGE_RISING ?
                    (I_EXT_IRQ_PIN && !st_ff.ext_prev) :
                    (!I_EXT_IRQ_PIN && st_ff.ext_prev);

  // event vector laid out like the flag bits
  always_comb begin
    evt_now = '0;
    evt_now[cics_pkg::CICS_TMR_FLAG_BIT] = I_TIMER_WRAP;
    evt_now[cics_pkg::CICS_EXT_FLAG_BIT] = ext_edge;
    evt_now[cics_pkg::CICS_CHG_FLAG_BIT] = chg.mismatch;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_prev = I_EXT_IRQ_PIN;
    // software write first, hardware set after it so the set wins
    if (wr_ics) begin
      nxt_st.ics = I_WDATA;
    end
    // flags ignore every enable bit; mismatch re-sets each cycle
    nxt_st.ics[cics_pkg::CICS_NEVT-1:0] =
      nxt_st.ics[cics_pkg::CICS_NEVT-1:0] | evt_now;
    // event status: write one to clear, new event wins
    if (wr_sts) begin
      nxt_st.evt_sts = st_ff.evt_sts & ~I_WDATA[cics_pkg::CICS_NEVT-1:0];
    end
    nxt_st.evt_sts = nxt_st.evt_sts | evt_now;
    if (wr_msk) begin
      nxt_st.evt_msk = I_WDATA[cics_pkg::CICS_NEVT-1:0];
    end
    // read data lives for exactly one cycle
    nxt_st.rdata = cics_pkg::CICS_RDATA_RST;
    if (I_RD) begin
      if (ics_hit) begin
        nxt_st.rdata = st_ff.ics;
      end else if (I_ADDR == cics_pkg::CICS_PORT_B_DATA_OFS) begin
        nxt_st.rdata = {I_UPPER_PORT_PINS, 4'h0};
      end else if (I_ADDR == cics_pkg::CICS_EVT_STS_OFS) begin
        nxt_st.rdata = {5'h00, st_ff.evt_sts};
      end else if (I_ADDR == cics_pkg::CICS_EVT_MSK_OFS) begin
        nxt_st.rdata = {5'h00, st_ff.evt_msk};
      end
    end
    // request follows the register value it is registered beside
    nxt_st.core_irq = nxt_st.ics[cics_pkg::CICS_GLOBAL_EN_BIT] &&
      ((nxt_st.ics[cics_pkg::CICS_TMR_EN_BIT] &&
        nxt_st.ics[cics_pkg::CICS_TMR_FLAG_BIT]) ||
       (nxt_st.ics[cics_pkg::CICS_EXT_EN_BIT] &&
        nxt_st.ics[cics_pkg::CICS_EXT_FLAG_BIT]) ||
       (nxt_st.ics[cics_pkg::CICS_CHG_EN_BIT] &&
        nxt_st.ics[cics_pkg::CICS_CHG_FLAG_BIT]) ||
       (nxt_st.ics[cics_pkg::CICS_PERIPH_EN_BIT] &&
        I_PERIPH_REQ));
    nxt_st.irq = |(nxt_st.evt_sts & nxt_st.evt_msk);
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      st_ff.ics <= cics_pkg::CICS_ICS_RST;
      st_ff.evt_sts <= cics_pkg::CICS_EVT_RST;
      st_ff.evt_msk <= cics_pkg::CICS_EVT_RST;
      st_ff.ext_prev <= 1'b0;
      st_ff.rdata <= cics_pkg::CICS_RDATA_RST;
      st_ff.core_irq <= 1'b0;
      st_ff.irq <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_RDATA = st_ff.rdata;
  assign O_CORE_IRQ = st_ff.core_irq;
  assign O_IRQ = st_ff.irq;

  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  flag_set_a: assert property (
    I_TIMER_WRAP |=> st_ff.ics[cics_pkg::CICS_TMR_FLAG_BIT])
    else $error("timer wrap did not set its flag");

  global_gate_a: assert property (
    !st_ff.ics[cics_pkg::CICS_GLOBAL_EN_BIT] |-> !O_CORE_IRQ)
    else $error("request raised with global enable clear");

  mirror_read_a: assert property (
    I_RD && I_ADDR == cics_pkg::CICS_ICS_OFS3 |=>
      O_RDATA == $past(st_ff.ics))
    else $error("mirrored read returned wrong value");

  mirror_write_a: assert property (
    I_WR && I_ADDR == cics_pkg::CICS_ICS_OFS2 && evt_now == '0 |=>
      st_ff.ics == $past(I_WDATA))
    else $error("mirrored write not stored");

  timer_gate_a: assert property (
    st_ff.ics[cics_pkg::CICS_GLOBAL_EN_BIT] &&
    st_ff.ics[cics_pkg::CICS_TMR_EN_BIT] &&
    st_ff.ics[cics_pkg::CICS_TMR_FLAG_BIT] |-> O_CORE_IRQ)
    else $error("enabled timer flag gave no request");

  ext_gate_a: assert property (
    st_ff.ics[cics_pkg::CICS_GLOBAL_EN_BIT] &&
    st_ff.ics[cics_pkg::CICS_EXT_EN_BIT] &&
    st_ff.ics[cics_pkg::CICS_EXT_FLAG_BIT] |-> O_CORE_IRQ)
    else $error("enabled external flag gave no request");

  port_persist_a: assert property (
    chg.mismatch && wr_ics |=>
      st_ff.ics[cics_pkg::CICS_CHG_FLAG_BIT])
    else $error("clear overrode a live port mismatch");

  no_self_clear_a: assert property (
    !wr_ics ##1 1'b1 |->
      (($past(st_ff.ics) & 8'h07) & ~(st_ff.ics & 8'h07)) == 8'h00)
    else $error("hardware cleared a flag on its own");

  ext_edge_a: assert property (
    I_EXT_EDGE_RISING && !I_EXT_IRQ_PIN ##1
    I_EXT_EDGE_RISING && I_EXT_IRQ_PIN |=>
      st_ff.ics[cics_pkg::CICS_EXT_FLAG_BIT])
    else $error("rising edge did not set the external flag");

  periph_gate_a: assert property (
    O_CORE_IRQ && !((st_ff.ics[cics_pkg::CICS_TMR_EN_BIT] &&
      st_ff.ics[cics_pkg::CICS_TMR_FLAG_BIT]) ||
      (st_ff.ics[cics_pkg::CICS_EXT_EN_BIT] &&
      st_ff.ics[cics_pkg::CICS_EXT_FLAG_BIT]) ||
      (st_ff.ics[cics_pkg::CICS_CHG_EN_BIT] &&
      st_ff.ics[cics_pkg::CICS_CHG_FLAG_BIT])) |->
      st_ff.ics[cics_pkg::CICS_PERIPH_EN_BIT])
    else $error("peripheral request passed with group enable clear");

  irq_level_a: assert property (
    O_IRQ |-> |(st_ff.evt_sts & st_ff.evt_msk))
    else $error("interrupt high with no unmasked status bit");

  core_irq_c: cover property ($rose(O_CORE_IRQ));

  port_clear_c: cover property (
    rd_port ##1 wr_ics && !I_WDATA[cics_pkg::CICS_CHG_FLAG_BIT] ##1
    !st_ff.ics[cics_pkg::CICS_CHG_FLAG_BIT]);

  evt_irq_c: cover property ($rose(O_IRQ) ##[1:10] !O_IRQ);

  periph_c: cover property (
    I_PERIPH_REQ && st_ff.ics[cics_pkg::CICS_PERIPH_EN_BIT] &&
    st_ff.ics[cics_pkg::CICS_GLOBAL_EN_BIT] ##1 O_CORE_IRQ);

endmodule

// >>> bench/cics_core_model.sv
// Purpose: processor core model driving the register port
// Assumes: one-cycle strobes, read data stands in the next cycle only
// Notes: released write data is inverted so a stale value never matches
`timescale 1ns/1ps
module cics_core_model (
  // clock
  input wire logic i_clk,
  // register port
  output logic [cics_pkg::CICS_AW-1:0] o_addr,
  output logic [cics_pkg::CICS_DW-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [cics_pkg::CICS_DW-1:0] i_rdata
);
  initial begin
    o_addr = 9'h000;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= v;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~v;
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(negedge i_clk);
    v = i_rdata;
  endtask

  // relatch first, else the mismatch sets the flag straight back
  task automatic clr_chg(input logic [7:0] ctl, output logic [7:0] pd);
    rd(cics_pkg::CICS_PORT_B_DATA_OFS, pd);
    wr(cics_pkg::CICS_ICS_OFS0, ctl & 8'hfe);
  endtask
endmodule

// >>> bench/cics_tb.sv
// Purpose: self-checking bench for the interrupt control block
// Assumes: core model owns the register port, bench drives the events
// Notes: every output check waits for the falling edge to avoid races
`timescale 1ns/1ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); \
  end \
end
module testbench;
  localparam logic [8:0] STS = cics_pkg::CICS_EVT_STS_OFS;
  localparam logic [8:0] MSK = cics_pkg::CICS_EVT_MSK_OFS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, wrap, ext, rising, preq, core_irq, irq;
  logic [3:0] pins;
  logic [8:0] ofs [4];
  int fails = 0;
  int compares = 0;

  always #20 clk = ~clk;

  cics_top dut (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TIMER_WRAP(wrap),
    .I_EXT_IRQ_PIN(ext), .I_EXT_EDGE_RISING(rising),
    .I_UPPER_PORT_PINS(pins), .I_PERIPH_REQ(preq),
    .O_CORE_IRQ(core_irq), .O_IRQ(irq)
  );
  cics_core_model core (
    .i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata)
  );

  task automatic finish_test;
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_rd(input logic [8:0] a, input logic [7:0] e);
    core.rd(a, d);
    `CHK(d, e)
  endtask

  task automatic chk_irq(input logic c, input logic e);
    @(negedge clk);
    `CHK(core_irq, c)
    `CHK(irq, e)
  endtask

  task automatic pulse;
    @(posedge clk);
    wrap <= 1'b1;
    @(posedge clk);
    wrap <= 1'b0;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    ofs = '{cics_pkg::CICS_ICS_OFS0, cics_pkg::CICS_ICS_OFS1,
            cics_pkg::CICS_ICS_OFS2, cics_pkg::CICS_ICS_OFS3};
    wrap = 1'b0;
    ext = 1'b0;
    rising = 1'b1;
    pins = 4'h0;
    preq = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk_rd(ofs[0], 8'h00);
    for (int i = 0; i < 4; i++) begin
      core.wr(ofs[i], 8'(8'h08 << i));
      chk_rd(ofs[(i + 1) % 4], 8'(8'h08 << i));
    end
    core.wr(9'h1ff, 8'hff);
    chk_rd(9'h1ff, 8'h00);
    chk_rd(ofs[3], 8'h40);
    // read data must fall back to zero one cycle later
    @(negedge clk);
    `CHK(rdata, 8'h00)
    // timer flag rises with every enable off
    core.wr(ofs[0], 8'h00);
    pulse();
    chk_irq(1'b0, 1'b0);
    chk_rd(ofs[1], 8'h04);
    core.wr(ofs[1], 8'h24);
    chk_irq(1'b0, 1'b0);
    core.wr(ofs[2], 8'ha4);
    chk_irq(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    chk_rd(ofs[3], 8'ha4);
    core.wr(ofs[0], 8'h80);
    pulse();
    chk_irq(1'b0, 1'b0);
    // one write clears flags and enables the external source
    core.wr(ofs[0], 8'h90);
    @(posedge clk);
    ext <= 1'b1;
    @(posedge clk);
    chk_irq(1'b1, 1'b0);
    chk_rd(ofs[0], 8'h92);
    core.wr(ofs[0], 8'h90);
    ext <= 1'b0;
    chk_rd(ofs[0], 8'h90);
    @(posedge clk);
    rising <= 1'b0;
    ext <= 1'b1;
    chk_rd(ofs[0], 8'h90);
    @(posedge clk);
    ext <= 1'b0;
    chk_rd(ofs[0], 8'h92);
    core.wr(ofs[0], 8'h82);
    chk_irq(1'b0, 1'b0);
    // port change: clear refused until the port is read
    core.wr(ofs[0], 8'h88);
    pins <= 4'ha;
    @(posedge clk);
    chk_irq(1'b1, 1'b0);
    core.wr(ofs[0], 8'h88);
    chk_rd(ofs[0], 8'h89);
    core.clr_chg(8'h89, d);
    `CHK(d, 8'ha0)
    chk_rd(ofs[0], 8'h88);
    chk_irq(1'b0, 1'b0);
    // peripheral group gate
    core.wr(ofs[0], 8'h80);
    preq <= 1'b1;
    @(posedge clk);
    chk_irq(1'b0, 1'b0);
    core.wr(ofs[0], 8'hc0);
    chk_irq(1'b1, 1'b0);
    core.wr(ofs[0], 8'h40);
    chk_irq(1'b0, 1'b0);
    @(posedge clk);
    preq <= 1'b0;
    // event status, mask and level interrupt
    core.wr(STS, 8'h07);
    core.wr(MSK, 8'h04);
    chk_rd(MSK, 8'h04);
    chk_irq(1'b0, 1'b0);
    pulse();
    chk_irq(1'b0, 1'b1);
    chk_rd(STS, 8'h04);
    core.wr(STS, 8'h01);
    chk_irq(1'b0, 1'b1);
    core.wr(STS, 8'h04);
    chk_irq(1'b0, 1'b0);
    // mid-run reset: pins stay high, so the cleared latch mismatches
    core.wr(ofs[0], 8'ha4);
    chk_irq(1'b1, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_irq(1'b0, 1'b0);
    chk_rd(ofs[0], 8'h01);
    chk_rd(MSK, 8'h00);
    finish_test();
  end
endmodule
